// ==== bspl_pkg.sv ====
// Purpose: shared constants for the burst sram port logic
// Assumes: strobe edges arrive as one-cycle enables on the system clock
// Notes: a position counts strobe edges since the accepting K edge
// Functional notes
// [RULE1] separate read outputs and write inputs
// [RULE2] one shared address bus, captured at different times
// [RULE3] four-word bursts, four one-word banks
// [RULE4] pll enabled: read latency 2.5 cycles
// [RULE5] pll disabled: legacy mode, latency 1 cycle
// [RULE6] accesses start only on positive strobe
// [RULE7] write data captured on both strobes
// [RULE8] read data launched on both strobes
// [RULE9] selects and byte selects registered on strobes
// [RULE10] read select latches read address
// [RULE11] read words follow latency, lowest word first
// [RULE12] back-to-back read request is ignored
// [RULE13] spaced reads stream without gaps
// [RULE14] read deselect: finish, then tristate after negative
// [RULE15] write select starts write at that address
// [RULE16] first write word next positive edge, byte gated
// [RULE17] write words collected over three more edges
// [RULE18] full burst committed at latched address
// [RULE19] back-to-back write request is ignored
// [RULE20] write deselect: finish, then ignore inputs
// [RULE21] each byte select gates its byte lane
// [RULE22] both selected: read first, then alternate
// [RULE23] read after write returns newest data
// [RULE24] controller drives selects active low
package bspl_pkg;
   localparam int DATA_W_DEF = 18; // narrow variant word width
   localparam int ADDR_W_DEF = 20; // address bits per bank
   localparam int BYTE_W = 9; // one byte lane incl. parity bit
   localparam int BURST_LEN = 4; // words per access
   localparam int LAT_PLL = 5; // 2.5 cycles in strobe edges
   localparam int LAT_LEGACY = 2; // 1 cycle in strobe edges
   localparam int WR_FIRST = 2; // edges from accept to first word
   localparam int WR_LAST = WR_FIRST + BURST_LEN - 1;
   localparam int RD_SPAN = LAT_PLL + BURST_LEN; // longest read reach
   localparam logic SEL_IDLE = 1'b1; // inactive level of a select
endpackage

// ==== bspl_link_if.sv ====
// Purpose: pin level link between controller and burst sram
// Assumes: both ends share one clock; strobes are enables
// Notes: selects and byte selects are active low
`timescale 1ns/1ns
interface bspl_link_if
   import bspl_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int ADDR_W = ADDR_W_DEF
);
   localparam int NB = DATA_W / BYTE_W;
   logic strobePos; // positive strobe rising edge
   logic strobeNeg; // negative strobe rising edge
   logic [ADDR_W-1:0] address; // shared address bus
   logic readPortSelectN; // read select, low active
   logic writePortSelectN; // write select, low active
   logic [NB-1:0] byteWriteSelectN; // byte lane selects, low active
   logic [DATA_W-1:0] writeData; // write port data
   logic [DATA_W-1:0] readData; // read port data
   logic readDataOe; // read port driven when high
   logic pllDisableN; // low selects legacy latency
   modport device (
      input strobePos, strobeNeg, address, readPortSelectN,
      input writePortSelectN, byteWriteSelectN, writeData, pllDisableN,
      output readData, readDataOe
   );
   modport ctrl (
      output strobePos, strobeNeg, address, readPortSelectN,
      output writePortSelectN, byteWriteSelectN, writeData, pllDisableN,
      input readData, readDataOe
   );
endinterface // bspl_link_if

// ==== bspl_bank.sv ====
// Purpose: one word-wide bank of the array with byte lane writes
// Assumes: one write per cycle, read is combinational
// Notes: contents are not reset
`timescale 1ns/1ns
module bspl_bank
   import bspl_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int ADDR_W = ADDR_W_DEF
) (
   // clock
   input wire logic clock,
   // write side
   input wire logic wrEn,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic [DATA_W/BYTE_W-1:0] wrByteEn,
   // read side
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic [DATA_W-1:0] rdData
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // bank storage

   // byte lane write, unselected lanes keep old contents
   always_ff @(posedge clock) begin
      if (wrEn) begin
         for (int n = 0; n < DATA_W / BYTE_W; n++) begin
            if (wrByteEn[n]) begin // [RULE21]
               mem[wrAddr][n*BYTE_W +: BYTE_W] <=
                  wrData[n*BYTE_W +: BYTE_W];
            end
         end
      end
   end

   // read port
   assign rdData = mem[rdAddr];
endmodule // bspl_bank

// ==== bspl_device.sv ====
// Purpose: device end of the burst sram port logic
// Assumes: controller gives one strobe edge per clock, alternating
// Notes: read data lags the accepting edge by the mode latency
`timescale 1ns/1ns
module bspl_device
   import bspl_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int ADDR_W = ADDR_W_DEF
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // link to the controller
   bspl_link_if.device link
);
   localparam int NB = DATA_W / BYTE_W; // byte lanes per word
   localparam int RD_LAST = RD_SPAN - 1; // last read position used

   typedef logic [DATA_W-1:0] bspl_word_t;
   typedef logic [ADDR_W-1:0] bspl_addr_t;
   typedef logic [NB-1:0] bspl_mask_t;

   // refuse widths that do not split into byte lanes
   if (DATA_W % BYTE_W != 0 || NB < 1 || ADDR_W < 1) begin : g_bad
      $error("bspl_device: word width must be whole byte lanes");
   end

   // read tokens, one slot per strobe edge since accept
   logic rdTok [1:RD_LAST];
   logic next_rdTok [1:RD_LAST];
   bspl_addr_t rdAddr [1:RD_LAST]; // read address register chain
   bspl_addr_t next_rdAddr [1:RD_LAST];
   // write tokens, same scheme
   logic wrTok [1:WR_LAST];
   logic next_wrTok [1:WR_LAST];
   bspl_addr_t wrAddr [1:WR_LAST]; // write address chain
   bspl_addr_t next_wrAddr [1:WR_LAST];
   // write data register and its byte masks
   bspl_word_t wData [BURST_LEN];
   bspl_word_t next_wData [BURST_LEN];
   bspl_mask_t wMask [BURST_LEN];
   bspl_mask_t next_wMask [BURST_LEN];
   // what the previous positive edge started
   logic lastRead;
   logic next_lastRead;
   logic lastWrite;
   logic next_lastWrite;
   // read output register
   bspl_word_t qData;
   bspl_word_t next_qData;
   logic qOe;
   logic next_qOe;

   // combinational helpers
   logic edgeAny; // any strobe edge this cycle
   logic acceptRead; // read started at this edge
   logic acceptWrite; // write started at this edge
   int lat; // read latency in strobe edges
   logic outAct; // a read word leaves at this edge
   int outWord; // which word of the burst
   bspl_addr_t outAddr; // its burst address
   bspl_word_t fwdWord; // array word with pending write merged
   bspl_word_t bankRd [BURST_LEN]; // bank read data
   logic commitEn; // burst goes into the array
   bspl_word_t commitData [BURST_LEN];
   bspl_mask_t commitMask [BURST_LEN];

   assign edgeAny = link.strobePos | link.strobeNeg;

   // arbitration and acceptance, only on the positive strobe
   always_comb begin
      acceptRead = link.strobePos // [RULE6] [RULE10]
         && (link.readPortSelectN != SEL_IDLE)
         && !lastRead; // [RULE12] [RULE22]
      acceptWrite = link.strobePos // [RULE6] [RULE15]
         && (link.writePortSelectN != SEL_IDLE)
         && !lastWrite // [RULE19]
         && !acceptRead; // [RULE22]
   end

   // token chains, address capture and history
   always_comb begin
      next_rdTok = rdTok;
      next_rdAddr = rdAddr;
      next_wrTok = wrTok;
      next_wrAddr = wrAddr;
      next_lastRead = lastRead;
      next_lastWrite = lastWrite;
      if (edgeAny) begin
         // advance every token by one edge
         for (int i = RD_LAST; i > 1; i--) begin
            next_rdTok[i] = rdTok[i-1];
            next_rdAddr[i] = rdAddr[i-1];
         end
         for (int i = WR_LAST; i > 1; i--) begin
            next_wrTok[i] = wrTok[i-1];
            next_wrAddr[i] = wrAddr[i-1];
         end
         // same bus, read and write latched on separate edges
         next_rdTok[1] = acceptRead;
         next_rdAddr[1] = link.address; // [RULE2] [RULE10]
         next_wrTok[1] = acceptWrite;
         next_wrAddr[1] = link.address; // [RULE2] [RULE15]
      end
      if (link.strobePos) begin
         // remember what this positive edge started
         next_lastRead = acceptRead;
         next_lastWrite = acceptWrite;
      end
   end

   // write word capture on both strobes, byte selects beside it
   always_comb begin
      next_wData = wData;
      next_wMask = wMask;
      for (int k = 0; k < BURST_LEN; k++) begin
         // outside a burst the write pins are ignored
         if (edgeAny && wrTok[WR_FIRST + k]) begin // [RULE20]
            next_wData[k] = link.writeData; // [RULE7] [RULE16] [RULE17]
            next_wMask[k] = ~link.byteWriteSelectN; // [RULE9] [RULE21]
         end
      end
   end

   // commit once the last word is on the pins
   always_comb begin
      commitEn = edgeAny && wrTok[WR_LAST]; // [RULE18]
      for (int k = 0; k < BURST_LEN; k++) begin
         if (k == BURST_LEN - 1) begin
            // last word goes straight from the pins
            commitData[k] = link.writeData;
            commitMask[k] = ~link.byteWriteSelectN;
         end else begin
            commitData[k] = wData[k];
            commitMask[k] = wMask[k];
         end
      end
   end

   // four banks, word k of every burst lives in bank k
   for (genvar b = 0; b < BURST_LEN; b++) begin : g_bank // [RULE3]
      bspl_bank #(
         .DATA_W(DATA_W),
         .ADDR_W(ADDR_W)
      ) u_bank (
         .clock(clock),
         .wrEn(commitEn),
         .wrAddr(wrAddr[WR_LAST]),
         .wrData(commitData[b]),
         .wrByteEn(commitMask[b]),
         .rdAddr(outAddr),
         .rdData(bankRd[b])
      );
   end

   // pick the read word due at this edge and merge pending writes
   always_comb begin
      // latency by mode pin
      lat = link.pllDisableN ? LAT_PLL : LAT_LEGACY; // [RULE4] [RULE5]
      outAct = 1'b0;
      outWord = 0;
      outAddr = '0;
      for (int k = 0; k < BURST_LEN; k++) begin
         // lowest word first, one word per edge
         if (rdTok[lat + k]) begin // [RULE11] [RULE13]
            outAct = 1'b1;
            outWord = k;
            outAddr = rdAddr[lat + k];
         end
      end
      fwdWord = bankRd[outWord];
      // captured but uncommitted bytes of the same address win
      for (int p = WR_FIRST + 1; p <= WR_LAST; p++) begin
         if (wrTok[p] && wrAddr[p] == outAddr
               && p > WR_FIRST + outWord) begin // [RULE23]
            for (int n = 0; n < NB; n++) begin
               if (wMask[outWord][n]) begin
                  fwdWord[n*BYTE_W +: BYTE_W] =
                     wData[outWord][n*BYTE_W +: BYTE_W];
               end
            end
         end
      end
   end

   // output register next values
   always_comb begin
      next_qData = qData;
      next_qOe = qOe;
      if (edgeAny) begin
         if (outAct) begin
            // launch on either strobe
            next_qData = fwdWord; // [RULE8]
            next_qOe = 1'b1;
         end else if (link.strobeNeg) begin
            // nothing pending: release the bus on a negative edge
            next_qOe = 1'b0; // [RULE14]
         end
      end
   end

   // state registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 1; i <= RD_LAST; i++) begin
            rdTok[i] <= 1'b0;
            rdAddr[i] <= '0;
         end
         for (int i = 1; i <= WR_LAST; i++) begin
            wrTok[i] <= 1'b0;
            wrAddr[i] <= '0;
         end
         for (int k = 0; k < BURST_LEN; k++) begin
            wData[k] <= '0;
            wMask[k] <= '0;
         end
         lastRead <= 1'b0;
         lastWrite <= 1'b0;
         qData <= '0;
         qOe <= 1'b0;
      end else begin
         rdTok <= next_rdTok;
         rdAddr <= next_rdAddr;
         wrTok <= next_wrTok;
         wrAddr <= next_wrAddr;
         wData <= next_wData;
         wMask <= next_wMask;
         lastRead <= next_lastRead;
         lastWrite <= next_lastWrite;
         qData <= next_qData;
         qOe <= next_qOe;
      end
   end

   // dedicated read port pins
   assign link.readData = qData; // [RULE1]
   assign link.readDataOe = qOe;
endmodule // bspl_device

// ==== bspl_ctrl.sv ====
// Purpose: controller end driving the burst sram link
// Assumes: user requests are taken only while ready is high
// Notes: makes the strobes itself by dividing the clock by two
`timescale 1ns/1ns
module bspl_ctrl
   import bspl_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int ADDR_W = ADDR_W_DEF
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // link to the device
   bspl_link_if.ctrl link,
   // mode
   input wire logic pllDisableN,
   // read requests
   input wire logic rdReq,
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic rdReady,
   output logic rdDone,
   output logic [BURST_LEN*DATA_W-1:0] rdData,
   // write requests
   input wire logic wrReq,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [BURST_LEN*DATA_W-1:0] wrData,
   input wire logic [BURST_LEN*(DATA_W/BYTE_W)-1:0] wrByteEn,
   output logic wrReady
);
   localparam int NB = DATA_W / BYTE_W;
   localparam int WR_DRV = WR_LAST - 1; // last drive position

   if (DATA_W % BYTE_W != 0 || NB < 1 || ADDR_W < 1) begin : g_bad
      $error("bspl_ctrl: word width must be whole byte lanes");
   end

   logic phase, next_phase; // low in positive strobe cycles
   logic rpsN, next_rpsN; // read select pin
   logic wpsN, next_wpsN; // write select pin
   logic [ADDR_W-1:0] addr, next_addr; // address pin
   logic [DATA_W-1:0] dOut, next_dOut; // write data pin
   logic [NB-1:0] bwsN, next_bwsN; // byte select pins
   logic wSel, next_wSel; // write buffer in use
   logic [DATA_W-1:0] wBufD [2][BURST_LEN]; // two write buffers
   logic [DATA_W-1:0] next_wBufD [2][BURST_LEN];
   logic [NB-1:0] wBufM [2][BURST_LEN]; // their byte enables
   logic [NB-1:0] next_wBufM [2][BURST_LEN];
   logic wTok [1:WR_DRV], next_wTok [1:WR_DRV]; // write in flight
   logic wTokSel [1:WR_DRV], next_wTokSel [1:WR_DRV];
   logic rTok [1:RD_SPAN], next_rTok [1:RD_SPAN]; // read in flight
   logic [BURST_LEN*DATA_W-1:0] next_rdData;
   logic next_rdDone;
   logic takeRd, takeWr; // user request taken
   int lat; // read latency in strobe edges

   // ready only before a positive edge the device will honour
   always_comb begin
      rdReady = phase && (rpsN == SEL_IDLE); // [RULE12]
      wrReady = phase && (wpsN == SEL_IDLE) // [RULE19]
         && !(rdReq && rdReady); // [RULE22]
      takeRd = rdReq && rdReady;
      takeWr = wrReq && wrReady;
   end

   // pins, buffers and tokens
   always_comb begin
      next_phase = ~phase;
      next_rpsN = rpsN;
      next_wpsN = wpsN;
      next_addr = addr;
      next_wSel = wSel;
      next_wBufD = wBufD;
      next_wBufM = wBufM;
      if (phase) begin
         // selects change only ahead of a positive edge
         next_rpsN = takeRd ? ~SEL_IDLE : SEL_IDLE; // [RULE6] [RULE24]
         next_wpsN = takeWr ? ~SEL_IDLE : SEL_IDLE; // [RULE24]
         if (takeRd) begin
            next_addr = rdAddr;
         end else if (takeWr) begin
            next_addr = wrAddr;
         end
      end
      if (takeWr) begin
         // fill the buffer not being drained
         next_wSel = ~wSel;
         for (int k = 0; k < BURST_LEN; k++) begin
            next_wBufD[~wSel][k] = wrData[k*DATA_W +: DATA_W];
            next_wBufM[~wSel][k] = wrByteEn[k*NB +: NB];
         end
      end
      for (int i = WR_DRV; i > 1; i--) begin
         next_wTok[i] = wTok[i-1];
         next_wTokSel[i] = wTokSel[i-1];
      end
      next_wTok[1] = !phase && (wpsN != SEL_IDLE);
      next_wTokSel[1] = wSel;
      next_dOut = dOut;
      next_bwsN = '1;
      for (int k = 0; k < BURST_LEN; k++) begin
         // word k on the pins for edge WR_FIRST + k
         if (wTok[WR_FIRST + k - 1]) begin // [RULE16] [RULE17]
            next_dOut = wBufD[wTokSel[WR_FIRST + k - 1]][k];
            next_bwsN = ~wBufM[wTokSel[WR_FIRST + k - 1]][k];
         end
      end
   end

   // read collection one cycle after the device output edge
   always_comb begin
      lat = pllDisableN ? LAT_PLL : LAT_LEGACY;
      for (int i = RD_SPAN; i > 1; i--) begin
         next_rTok[i] = rTok[i-1];
      end
      next_rTok[1] = !phase && (rpsN != SEL_IDLE);
      next_rdData = rdData;
      next_rdDone = 1'b0;
      for (int k = 0; k < BURST_LEN; k++) begin
         if (rTok[lat + k + 1]) begin
            next_rdData[k*DATA_W +: DATA_W] = link.readData;
            next_rdDone = (k == BURST_LEN - 1);
         end
      end
   end

   // state registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         phase <= 1'b0;
         rpsN <= SEL_IDLE;
         wpsN <= SEL_IDLE;
         addr <= '0;
         dOut <= '0;
         bwsN <= '1;
         wSel <= 1'b0;
         for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < BURST_LEN; k++) begin
               wBufD[s][k] <= '0;
               wBufM[s][k] <= '0;
            end
         end
         for (int i = 1; i <= WR_DRV; i++) begin
            wTok[i] <= 1'b0;
            wTokSel[i] <= 1'b0;
         end
         for (int i = 1; i <= RD_SPAN; i++) begin
            rTok[i] <= 1'b0;
         end
         rdData <= '0;
         rdDone <= 1'b0;
      end else begin
         phase <= next_phase;
         rpsN <= next_rpsN;
         wpsN <= next_wpsN;
         addr <= next_addr;
         dOut <= next_dOut;
         bwsN <= next_bwsN;
         wSel <= next_wSel;
         wBufD <= next_wBufD;
         wBufM <= next_wBufM;
         wTok <= next_wTok;
         wTokSel <= next_wTokSel;
         rTok <= next_rTok;
         rdData <= next_rdData;
         rdDone <= next_rdDone;
      end
   end

   // link pins
   assign link.strobePos = ~phase;
   assign link.strobeNeg = phase;
   assign link.address = addr;
   assign link.readPortSelectN = rpsN;
   assign link.writePortSelectN = wpsN;
   assign link.byteWriteSelectN = bwsN;
   assign link.writeData = dOut;
   assign link.pllDisableN = pllDisableN;
endmodule // bspl_ctrl

// ==== bspl_link_monitor.sv ====
// Purpose: link checker for the burst sram port logic
// Assumes: strobes are one-cycle enables on the clock
// Notes: acceptance is rebuilt from the link pins
`timescale 1ns/1ns
module bspl_link_monitor
   import bspl_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int ADDR_W = ADDR_W_DEF
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // link signals
   input wire logic strobePos,
   input wire logic strobeNeg,
   input wire logic [ADDR_W-1:0] address,
   input wire logic readPortSelectN,
   input wire logic writePortSelectN,
   input wire logic [DATA_W/BYTE_W-1:0] byteWriteSelectN,
   input wire logic [DATA_W-1:0] writeData,
   input wire logic [DATA_W-1:0] readData,
   input wire logic readDataOe,
   input wire logic pllDisableN
);
   logic rdAcc; // read accepted at this edge
   logic wrAcc; // write accepted at this edge
   logic rdPrev; // read taken at last positive edge
   logic wrPrev; // write taken at last positive edge
   logic next_rdPrev; // next value of rdPrev
   logic next_wrPrev; // next value of wrPrev
   // acceptance as the device must judge it
   always_comb begin
      rdAcc = strobePos && !readPortSelectN && !rdPrev;
      wrAcc = strobePos && !writePortSelectN && !wrPrev && !rdAcc;
      next_rdPrev = strobePos ? rdAcc : rdPrev;
      next_wrPrev = strobePos ? wrAcc : wrPrev;
   end
   // hold acceptance across one positive edge
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdPrev <= 1'h0;
         wrPrev <= 1'h0;
      end else begin
         rdPrev <= next_rdPrev;
         wrPrev <= next_wrPrev;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   AST_STROBE_ONEHOT:
   assert property (strobePos != strobeNeg) else $error("strobes clash");
   AST_STROBE_ALT:
   assert property (strobeNeg |=> strobePos) else $error("no positive edge");
   AST_OE_PLL:
   assert property (rdAcc && pllDisableN |-> ##6 readDataOe [*4])
      else $error("pll read data late");
   AST_OE_LEGACY:
   assert property (rdAcc && !pllDisableN |-> ##3 readDataOe [*4])
      else $error("legacy read data late");
   AST_OE_CAUSE:
   assert property ($rose(readDataOe) |->
      (pllDisableN ? $past(rdAcc, 6) : $past(rdAcc, 3)))
      else $error("read port driven without read");
   AST_OE_RELEASE:
   assert property ($fell(readDataOe) |-> $past(strobeNeg))
      else $error("read port released off negative edge");
   AST_STREAM:
   assert property ((rdAcc && pllDisableN) ##4 rdAcc |-> ##2 readDataOe [*8])
      else $error("gap in read stream");
   AST_RD_SPACING:
   assert property (rdAcc |-> ##2 readPortSelectN)
      else $error("reads on adjacent edges");
   AST_WR_SPACING:
   assert property (wrAcc |-> ##2 writePortSelectN)
      else $error("writes on adjacent edges");
   AST_BWS_IDLE:
   assert property (byteWriteSelectN != '1 |-> $past(wrAcc, 2)
      || $past(wrAcc, 3) || $past(wrAcc, 4) || $past(wrAcc, 5))
      else $error("byte selects active outside a write burst");
   // main scenarios
   cover property (rdAcc && pllDisableN);
   cover property (rdAcc && !pllDisableN);
   cover property (wrAcc ##2 rdAcc);
   cover property (rdAcc ##4 rdAcc);
endmodule // bspl_link_monitor

// ==== burst_sram_port_logic_bench.sv ====
// Purpose: self-checking bench for the burst sram port logic
// Assumes: controller and device meet over one link interface
// Notes: short address width keeps the array model small
`timescale 1ns/1ns
module burst_sram_port_logic_bench
   import bspl_pkg::*;
();
   localparam int DW = DATA_W_DEF; // word width
   localparam int AW = 4; // shortened address width
   localparam int BW = BURST_LEN * DW; // burst width
   localparam int BE = BURST_LEN * (DW / BYTE_W); // lanes per burst
   logic clock; // system clock
   logic resetn; // low active reset
   logic pllDisableN; // latency mode
   logic rdReq; // read request
   logic [AW-1:0] rdAddr; // read address
   logic rdReady; // read may be taken
   logic rdDone; // read burst complete
   logic [BW-1:0] rdData; // read burst
   logic wrReq; // write request
   logic [AW-1:0] wrAddr; // write address
   logic [BW-1:0] wrData; // write burst
   logic [BE-1:0] wrByteEn; // lane enables
   logic wrReady; // write may be taken
   logic [BW-1:0] mem [2**AW]; // array model
   logic [BW-1:0] expData[$]; // expected bursts
   int expCyc[$]; // expected done cycles
   int cyc; // cycle count
   int num_errors; // mismatches
   int check_count; // comparisons
   int seed; // random seed
   logic [BW-1:0] wNew; // burst of the contested write
   bspl_link_if #(.DATA_W(DW), .ADDR_W(AW)) bspl_link_if_i ();
   bspl_ctrl #(.DATA_W(DW), .ADDR_W(AW)) bspl_ctrl_i (
      .clock(clock), .resetn(resetn), .link(bspl_link_if_i.ctrl),
      .pllDisableN(pllDisableN), .rdReq(rdReq), .rdAddr(rdAddr),
      .rdReady(rdReady), .rdDone(rdDone), .rdData(rdData),
      .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData),
      .wrByteEn(wrByteEn), .wrReady(wrReady));
   bspl_device #(.DATA_W(DW), .ADDR_W(AW)) bspl_device_i (
      .clock(clock), .resetn(resetn), .link(bspl_link_if_i.device));
   bspl_link_monitor #(.DATA_W(DW), .ADDR_W(AW)) bspl_link_monitor_i (
      .clock(clock), .resetn(resetn),
      .strobePos(bspl_link_if_i.strobePos),
      .strobeNeg(bspl_link_if_i.strobeNeg),
      .address(bspl_link_if_i.address),
      .readPortSelectN(bspl_link_if_i.readPortSelectN),
      .writePortSelectN(bspl_link_if_i.writePortSelectN),
      .byteWriteSelectN(bspl_link_if_i.byteWriteSelectN),
      .writeData(bspl_link_if_i.writeData),
      .readData(bspl_link_if_i.readData),
      .readDataOe(bspl_link_if_i.readDataOe),
      .pllDisableN(bspl_link_if_i.pllDisableN));
   // clock and cycle count
   always #5 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   // one comparison, counted
   task automatic chk(input logic [BW-1:0] got, input logic [BW-1:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // random burst from the seed
   function automatic logic [BW-1:0] rnd();
      logic [95:0] t;
      t = {$random(seed), $random(seed), $random(seed)};
      return t[BW-1:0];
   endfunction
   // write request, model updated at the take
   task automatic do_wr(input logic [AW-1:0] a, input logic [BW-1:0] d,
      input logic [BE-1:0] e);
      int n;
      @(posedge clock);
      #1;
      wrReq = 1'h1;
      wrAddr = a;
      wrData = d;
      wrByteEn = e;
      n = 0;
      @(negedge clock);
      while (wrReady !== 1'h1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      chk(wrReady, 1'h1);
      @(posedge clock);
      for (int j = 0; j < BE; j++) begin
         if (e[j]) mem[a][j*BYTE_W +: BYTE_W] = d[j*BYTE_W +: BYTE_W];
      end
      #1;
      wrReq = 1'h0;
   endtask
   // read request, expectation noted at the take
   task automatic do_rd(input logic [AW-1:0] a);
      int n;
      @(posedge clock);
      #1;
      rdReq = 1'h1;
      rdAddr = a;
      n = 0;
      @(negedge clock);
      while (rdReady !== 1'h1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      chk(rdReady, 1'h1);
      expData.push_back(mem[a]);
      expCyc.push_back(cyc + 6 + (pllDisableN ? LAT_PLL : LAT_LEGACY));
      @(posedge clock);
      #1;
      rdReq = 1'h0;
   endtask
   // results checked against the oldest note, mid-cycle where settled
   always @(negedge clock) begin
      if (rdDone === 1'h1) begin
         if (expData.size() == 0) begin
            chk(rdDone, 1'h0);
         end else begin
            chk(rdData, expData.pop_front());
            chk(cyc, expCyc.pop_front());
         end
      end
   end
   // verdict and end of run
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (4000) @(posedge clock);
      num_errors++;
      final_report();
   end
   // main sequence
   initial begin
      seed = 54992;
      clock = 1'h0;
      resetn = 1'h0;
      pllDisableN = 1'h1;
      rdReq = 1'h0;
      wrReq = 1'h0;
      rdAddr = '0;
      wrAddr = '0;
      wrData = '0;
      wrByteEn = '0;
      cyc = 0;
      num_errors = 0;
      check_count = 0;
      repeat (12) @(posedge clock);
      #1;
      resetn = 1'h1;
      // two passes: pll latency, then legacy latency
      for (int m = 0; m < 2; m++) begin
         for (int a = 0; a < 2**AW; a++) do_wr(a, rnd(), '1);
         do_wr(1, rnd(), '1);
         @(posedge clock);
         @(negedge clock);
         chk(wrReady, 1'h0);
         do_rd(0);
         @(posedge clock);
         @(negedge clock);
         chk(rdReady, 1'h0);
         for (int a = 1; a < 2**AW; a++) do_rd(a);
         // partial lanes, read right after the write
         for (int i = 0; i < 6; i++) begin
            do_wr(i, rnd(), BE'($random(seed)));
            do_rd(i);
         end
         // both requests at once from idle: read first
         repeat (4) @(posedge clock);
         wNew = rnd();
         fork
            do_rd(7);
            do_wr(7, wNew, '1);
         join
         // pll read words leave after this write lands: newest data
         if (pllDisableN) expData[expData.size() - 1] = wNew;
         do_rd(7);
         repeat (20) @(posedge clock);
         #1;
         pllDisableN = 1'h0;
         repeat (4) @(posedge clock);
      end
      repeat (20) @(posedge clock);
      chk(expData.size(), 0);
      final_report();
   end
endmodule // burst_sram_port_logic_bench
